// >>> src/cdsl_pkg.sv
// Package for the core drive steering logic: drive bundle, states and timing counts.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package cdsl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CDSL_CLK_NS = 25;
  localparam int CDSL_RD_NS = 250;
  localparam int CDSL_WR_NS = 250;
  localparam int CDSL_RISE_NS = 50;
  localparam int CDSL_RD_CYC = CDSL_RD_NS / CDSL_CLK_NS;
  localparam int CDSL_WR_CYC = CDSL_WR_NS / CDSL_CLK_NS;
  localparam int CDSL_RISE_CYC = (CDSL_RISE_NS + CDSL_CLK_NS - 1) / CDSL_CLK_NS;
  localparam int CDSL_CNT_W = 4;

  // ----------------------------------------------------------------
  // Address field positions (address is A[14:1])
  // ----------------------------------------------------------------
  localparam int CDSL_ADDR_HI = 14;
  localparam int CDSL_ADDR_LO = 1;
  localparam int CDSL_HALF_BIT = 14;
  localparam int CDSL_XWIN_HI = 13;
  localparam int CDSL_XWIN_LO = 7;
  localparam int CDSL_XWIN_W = CDSL_XWIN_HI - CDSL_XWIN_LO + 1;
  localparam int CDSL_XDRV_N = 8;
  localparam int CDSL_XSW_N = 16;

  typedef enum logic [1:0] {
    CDSL_IDLE  = 2'h0,
    CDSL_READ  = 2'h1,
    CDSL_WRITE = 2'h3,
    CDSL_RECOV = 2'h2
  } cdsl_state_t;

  typedef struct packed {
    logic x_rd_src_n;
    logic x_rd_snk_n;
    logic x_wr_src_n;
    logic x_wr_snk_n;
    logic x_rd_isrc;
    logic x_wr_isrc;
    logic y_com_src_timing_n;
    logic y_dio_snk_timing_n;
    logic y_dio_src_timing_n;
    logic y_com_snk_timing_n;
    logic y_dio_isrc;
    logic y_com_isrc;
  } cdsl_drive_t;

  localparam cdsl_drive_t CDSL_DRIVE_RST = 12'hF3C;

  typedef struct packed {
    logic [CDSL_XDRV_N-1:0] drv_sel;
    logic [CDSL_XSW_N-1:0] sw_sel;
    logic bank;
  } cdsl_xsel_t;

  localparam cdsl_xsel_t CDSL_XSEL_RST = 25'h0000000;

endpackage : cdsl_pkg

// >>> src/cdsl_xdec.sv
// X winding decoder: turns address bits 13..7 into driver and switch selects.
// Assumes bits arrive active high (already inverted from the low-true bus).
`timescale 1ns/1ps
module cdsl_xdec (
  input wire logic [cdsl_pkg::CDSL_XWIN_W-1:0] xwin_in, // Address bits 13..7, high true.
  input wire logic enable_in, // Drive select is live.
  output cdsl_pkg::cdsl_xsel_t xsel_out // One-hot selects and decoder bank.
);
  import cdsl_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Bit 13 picks the decoder bank, so all-zero selects output zero of the
  // first bank and bit 13 alone selects output zero of the other bank.
  logic [2:0] drv_idx;
  logic [3:0] sw_idx;
  assign drv_idx = xwin_in[6:4];
  assign sw_idx = xwin_in[3:0];

  genvar gi;
  generate
    for (gi = 0; gi < CDSL_XDRV_N; gi++) begin : g_drv
      assign xsel_out.drv_sel[gi] = enable_in && (drv_idx == 3'(gi));
    end
    for (gi = 0; gi < CDSL_XSW_N; gi++) begin : g_sw
      assign xsel_out.sw_sel[gi] = enable_in && (sw_idx == 4'(gi));
    end
  endgenerate
  assign xsel_out.bank = enable_in && xwin_in[6];

endmodule : cdsl_xdec

// >>> src/cdsl_steer.sv
// Core drive steering: read/write X timing, Y half-select multiplexer, inhibit and charge.
// Assumes cycle request, address and data-zero pins come from outside the clock domain.
`timescale 1ns/1ps
module cdsl_steer (
  input wire logic clk_in, // 40 MHz clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic cycle_req_in, // Cycle request for an assigned address, level.
  input wire logic [cdsl_pkg::CDSL_ADDR_HI:cdsl_pkg::CDSL_ADDR_LO] addr_n_in, // Low-true address.
  input wire logic [1:0] byte_zero_in, // Per byte: zeros to be written.
  output cdsl_pkg::cdsl_drive_t drive_out, // X and Y timing and source enables.
  output cdsl_pkg::cdsl_xsel_t xsel_out, // X winding selects.
  output logic inhibit_rise_n_out, // Inhibit rise time, low true.
  output logic inhibit_low_byte_n_out, // Bits 0-7 inhibit time, low true.
  output logic inhibit_high_byte_n_out, // Bits 8-15 inhibit time, low true.
  output logic x_matrix_charge_on_out, // X stack charge on.
  output logic addr_hold_a_n_out, // Address hold, first copy, low true.
  output logic addr_hold_b_n_out, // Address hold, second copy, low true.
  output logic upper_half_select_out // Latched upper-half select.
);
  import cdsl_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic req_s1_ff, req_s2_ff, req_s3_ff;
  logic [CDSL_ADDR_HI:CDSL_ADDR_LO] addr_s1_ff, addr_s2_ff;
  logic [1:0] zero_s1_ff, zero_s2_ff;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
      addr_s1_ff <= '1;
      addr_s2_ff <= '1;
      zero_s1_ff <= 2'h0;
      zero_s2_ff <= 2'h0;
    end else begin
      req_s1_ff <= cycle_req_in;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      addr_s1_ff <= addr_n_in;
      addr_s2_ff <= addr_s1_ff;
      zero_s1_ff <= byte_zero_in;
      zero_s2_ff <= zero_s1_ff;
    end
  end

  logic start;
  assign start = req_s2_ff && !req_s3_ff;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  cdsl_state_t state_ff, nxt_state;
  logic [CDSL_CNT_W-1:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 4'h1;
    unique case (state_ff)
      CDSL_IDLE: begin
        nxt_cnt = 4'h0;
        if (start) begin
          nxt_state = CDSL_READ;
        end
      end
      CDSL_READ: begin
        if (cnt_ff == CDSL_CNT_W'(CDSL_RD_CYC - 1)) begin
          nxt_state = CDSL_WRITE;
          nxt_cnt = 4'h0;
        end
      end
      CDSL_WRITE: begin
        if (cnt_ff == CDSL_CNT_W'(CDSL_WR_CYC - 1)) begin
          nxt_state = CDSL_RECOV;
          nxt_cnt = 4'h0;
        end
      end
      CDSL_RECOV: begin
        nxt_state = CDSL_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff <= CDSL_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Address and data latch
  // ----------------------------------------------------------------
  logic [CDSL_ADDR_HI:CDSL_ADDR_LO] addr_n_ff;
  logic [1:0] zero_ff;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      addr_n_ff <= '1;
      zero_ff <= 2'h0;
    end else if (state_ff == CDSL_IDLE && start) begin
      addr_n_ff <= addr_s2_ff;
      zero_ff <= zero_s2_ff;
    end
  end

  logic upper;
  assign upper = !addr_n_ff[CDSL_HALF_BIT];

  // ----------------------------------------------------------------
  // Drive steering
  // ----------------------------------------------------------------
  function automatic cdsl_drive_t drive_of(input cdsl_state_t st, input logic up);
    cdsl_drive_t d;
    logic rd, wr;
    rd = (st == CDSL_READ);
    wr = (st == CDSL_WRITE);
    d.x_rd_src_n = !rd;
    d.x_rd_snk_n = !rd;
    d.x_wr_src_n = !wr;
    d.x_wr_snk_n = !wr;
    d.x_rd_isrc = rd;
    d.x_wr_isrc = wr;
    d.y_com_src_timing_n = up ? !wr : !rd;
    d.y_dio_snk_timing_n = up ? !wr : !rd;
    d.y_dio_src_timing_n = up ? !rd : !wr;
    d.y_com_snk_timing_n = up ? !rd : !wr;
    d.y_dio_isrc = up ? rd : wr;
    d.y_com_isrc = up ? wr : rd;
    return d;
  endfunction : drive_of

  logic nxt_upper;
  logic [CDSL_ADDR_HI:CDSL_ADDR_LO] nxt_addr_n;
  assign nxt_addr_n = (state_ff == CDSL_IDLE && start) ? addr_s2_ff : addr_n_ff;
  assign nxt_upper = !nxt_addr_n[CDSL_HALF_BIT];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      drive_out <= CDSL_DRIVE_RST;
      upper_half_select_out <= 1'b0;
    end else begin
      drive_out <= drive_of(nxt_state, nxt_upper);
      upper_half_select_out <= nxt_upper;
    end
  end

  // ----------------------------------------------------------------
  // X winding select
  // ----------------------------------------------------------------
  cdsl_xsel_t xsel_nxt;
  logic xdec_en;
  assign xdec_en = (nxt_state == CDSL_READ) || (nxt_state == CDSL_WRITE);

  cdsl_xdec u_xdec (
    .xwin_in(~nxt_addr_n[CDSL_XWIN_HI:CDSL_XWIN_LO]),
    .enable_in(xdec_en),
    .xsel_out(xsel_nxt)
  );

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      xsel_out <= CDSL_XSEL_RST;
    end else begin
      xsel_out <= xsel_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Inhibit, stack charge and address hold
  // ----------------------------------------------------------------
  logic nxt_wr;
  assign nxt_wr = (nxt_state == CDSL_WRITE);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      inhibit_rise_n_out <= 1'b1;
      inhibit_low_byte_n_out <= 1'b1;
      inhibit_high_byte_n_out <= 1'b1;
      x_matrix_charge_on_out <= 1'b0;
      addr_hold_a_n_out <= 1'b1;
      addr_hold_b_n_out <= 1'b1;
    end else begin
      inhibit_rise_n_out <= !(nxt_wr && (|zero_ff) &&
                              nxt_cnt < CDSL_CNT_W'(CDSL_RISE_CYC));
      inhibit_low_byte_n_out <= !(nxt_wr && zero_ff[0]);
      inhibit_high_byte_n_out <= !(nxt_wr && zero_ff[1]);
      x_matrix_charge_on_out <= nxt_wr;
      addr_hold_a_n_out <= (nxt_state == CDSL_IDLE);
      addr_hold_b_n_out <= (nxt_state == CDSL_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int RD_LEN = CDSL_RD_CYC;

  property p_rd_then_wr;
    @(posedge clk_in) disable iff (srst_in)
    $rose(drive_out.x_wr_isrc) |-> $past(drive_out.x_rd_isrc);
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("write half without read");

  property p_x_opposite;
    @(posedge clk_in) disable iff (srst_in)
    !(!drive_out.x_rd_src_n && !drive_out.x_wr_src_n);
  endproperty
  a_x_opposite: assert property (p_x_opposite) else $error("X read and write overlap");

  property p_rd_len;
    @(posedge clk_in) disable iff (srst_in)
    $fell(drive_out.x_rd_src_n) |-> !drive_out.x_rd_snk_n ##RD_LEN $rose(drive_out.x_rd_src_n);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read half length wrong");

  property p_wr_pair;
    @(posedge clk_in) disable iff (srst_in)
    (drive_out.x_wr_src_n == drive_out.x_wr_snk_n) &&
    (drive_out.x_wr_isrc == !drive_out.x_wr_src_n);
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("X write pair mismatch");

  property p_inh_rise;
    @(posedge clk_in) disable iff (srst_in)
    $fell(inhibit_rise_n_out) |-> $fell(drive_out.x_wr_src_n) ##1 !inhibit_rise_n_out;
  endproperty
  a_inh_rise: assert property (p_inh_rise) else $error("inhibit rise misplaced");

  property p_inh_byte;
    @(posedge clk_in) disable iff (srst_in)
    (!inhibit_low_byte_n_out || !inhibit_high_byte_n_out) |->
    !drive_out.x_wr_src_n && x_matrix_charge_on_out;
  endproperty
  a_inh_byte: assert property (p_inh_byte) else $error("inhibit outside write");

  property p_y_lower;
    @(posedge clk_in) disable iff (srst_in)
    !upper_half_select_out |-> drive_out.y_com_src_timing_n == drive_out.x_rd_src_n &&
    drive_out.y_dio_src_timing_n == drive_out.x_wr_src_n;
  endproperty
  a_y_lower: assert property (p_y_lower) else $error("lower half Y steering wrong");

  property p_y_upper;
    @(posedge clk_in) disable iff (srst_in)
    upper_half_select_out |-> drive_out.y_dio_src_timing_n == drive_out.x_rd_src_n &&
    drive_out.y_com_src_timing_n == drive_out.x_wr_src_n && drive_out.y_dio_isrc == !drive_out.x_rd_src_n;
  endproperty
  a_y_upper: assert property (p_y_upper) else $error("upper half Y steering wrong");

  property p_half_stable;
    @(posedge clk_in) disable iff (srst_in)
    !addr_hold_a_n_out && $past(!addr_hold_a_n_out) |-> $stable(upper_half_select_out);
  endproperty
  a_half_stable: assert property (p_half_stable) else $error("half select moved in cycle");

  property p_xdec_zero;
    @(posedge clk_in) disable iff (srst_in)
    (!drive_out.x_rd_src_n && addr_n_ff[13:7] == 7'h7F) |-> xsel_out.drv_sel == 8'h01 &&
    xsel_out.sw_sel == 16'h0001 && !xsel_out.bank;
  endproperty
  a_xdec_zero: assert property (p_xdec_zero) else $error("X decode of zero wrong");

  c_lower: cover property (@(posedge clk_in) disable iff (srst_in)
    !upper_half_select_out && $rose(drive_out.x_wr_isrc));
  c_upper: cover property (@(posedge clk_in) disable iff (srst_in)
    upper_half_select_out && $rose(drive_out.x_wr_isrc));
  c_inhibit_both: cover property (@(posedge clk_in) disable iff (srst_in)
    !inhibit_low_byte_n_out && !inhibit_high_byte_n_out);

endmodule : cdsl_steer

// >>> tb/cdsl_stack_model.sv
// Model of the stack drivers, current generators and inhibit drivers.
// Assumes the steering outputs drive it directly; it reports the currents that flow.
`timescale 1ns/1ps
module cdsl_stack_model (
  input wire cdsl_pkg::cdsl_drive_t drive_in, // Steering drive bundle.
  input wire logic inh_lo_n_in, // Low byte inhibit time, low true.
  input wire logic inh_hi_n_in, // High byte inhibit time, low true.
  output logic [1:0] x_dir_out, // X current: bit 0 read way, bit 1 write way.
  output logic [1:0] y_dir_out, // Y current: bit 0 common to diode, bit 1 reverse.
  output logic [1:0] inh_on_out // Inhibit current per byte.
);
  import cdsl_pkg::*;
  // ----------------------------------------------------------------
  // Current paths
  // ----------------------------------------------------------------
  // An X or Y path conducts only when source, sink and its generator are all on.
  assign x_dir_out[0] = !drive_in.x_rd_src_n && !drive_in.x_rd_snk_n
    && drive_in.x_rd_isrc;
  assign x_dir_out[1] = !drive_in.x_wr_src_n && !drive_in.x_wr_snk_n
    && drive_in.x_wr_isrc;
  assign y_dir_out[0] = !drive_in.y_com_src_timing_n && !drive_in.y_dio_snk_timing_n
    && drive_in.y_com_isrc;
  assign y_dir_out[1] = !drive_in.y_dio_src_timing_n && !drive_in.y_com_snk_timing_n
    && drive_in.y_dio_isrc;
  assign inh_on_out = {!inh_hi_n_in, !inh_lo_n_in};
endmodule : cdsl_stack_model

// >>> tb/tb_core_drive_steering_logic.sv
// Testbench for the steering block: walks whole cycles and checks every output.
// Assumes a 40 MHz clock and inputs changed 1 ns after the rising edge, except the request drop after a cycle, made on the falling edge.
`timescale 1ns/1ps
module tb_core_drive_steering_logic;
  import cdsl_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cycle_req_in = 1'b0;
  logic [14:1] addr_n_in = 14'h3FFF;
  logic [1:0] byte_zero_in = 2'h0;
  cdsl_drive_t drive_out;
  cdsl_xsel_t xsel_out;
  logic rise_n, lo_n, hi_n, charge, hold_a_n, hold_b_n, upper;
  logic [1:0] x_dir, y_dir, inh_on;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ----------------------------------------------------------------
  // Clock, design and model
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  cdsl_steer u_cdsl_steer (.clk_in(clk_in), .srst_in(srst_in), .cycle_req_in(cycle_req_in),
    .addr_n_in(addr_n_in), .byte_zero_in(byte_zero_in), .drive_out(drive_out),
    .xsel_out(xsel_out), .inhibit_rise_n_out(rise_n), .inhibit_low_byte_n_out(lo_n),
    .inhibit_high_byte_n_out(hi_n), .x_matrix_charge_on_out(charge),
    .addr_hold_a_n_out(hold_a_n), .addr_hold_b_n_out(hold_b_n),
    .upper_half_select_out(upper));
  cdsl_stack_model u_cdsl_stack_model (.drive_in(drive_out), .inh_lo_n_in(lo_n),
    .inh_hi_n_in(hi_n), .x_dir_out(x_dir), .y_dir_out(y_dir), .inh_on_out(inh_on));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Raises the request and walks one cycle; pulse drops and raises it mid-cycle.
  task automatic run_cycle(input logic [14:1] an, input logic [1:0] bz, input bit pulse);
    logic [14:1] a;
    logic rd, wr, cp, dp;
    cdsl_drive_t ed;
    cdsl_xsel_t ex;
    bit ok;
    a = ~an;
    ok = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    addr_n_in = an;
    byte_zero_in = bz;
    cycle_req_in = 1'b1;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(negedge clk_in);
      ok = (drive_out.x_rd_src_n === 1'b0);
    end
    if (!ok) begin
      chk("cycle start", 1, 0);
      stop_test();
    end
    for (int k = 0; k < 22; k++) begin
      rd = k < 10;
      wr = k >= 10 && k < 20;
      cp = a[14] ? wr : rd;
      dp = a[14] ? rd : wr;
      ed = {!rd, !rd, !wr, !wr, rd, wr, !cp, !cp, !dp, !dp, dp, cp};
      ex = '0;
      if (rd || wr) begin
        ex.drv_sel[a[13:11]] = 1'b1;
        ex.sw_sel[a[10:7]] = 1'b1;
        ex.bank = a[13];
      end
      chk("drive", 32'(ed), 32'(drive_out));
      chk("xsel", 32'(ex), 32'(xsel_out));
      chk("x_dir", 32'({wr, rd}), 32'(x_dir));
      chk("y_dir", 32'({dp, cp}), 32'(y_dir));
      chk("rise", 32'(!(k >= 10 && k < 12 && |bz)), 32'(rise_n));
      chk("inh", 32'({wr & bz[1], wr & bz[0]}), 32'(inh_on));
      chk("charge", 32'(wr), 32'(charge));
      chk("hold", 32'({2{k > 20}}), 32'({hold_a_n, hold_b_n}));
      if (k < 20) begin
        chk("upper", 32'(a[14]), 32'(upper));
      end
      @(posedge clk_in);
      #1;
      if (k == 1) begin
        addr_n_in = ~an;
        byte_zero_in = ~bz;
      end
      if (pulse && k == 4) begin
        cycle_req_in = 1'b0;
      end
      if (pulse && k == 6) begin
        cycle_req_in = 1'b1;
      end
      @(negedge clk_in);
    end
    if (!pulse) begin
      cycle_req_in = 1'b0;
    end
  endtask : run_cycle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(negedge clk_in);
    chk("rst drive", 32'h00000F3C, 32'(drive_out));
    chk("rst xsel", 32'h0, 32'(xsel_out));
    chk("rst pins", 32'h3F, 32'({rise_n, lo_n, hi_n, hold_a_n, hold_b_n, !charge}));
  endtask : t_reset
  task automatic t_lower();
    run_cycle(14'h3FFF, 2'h1, 1'b0);
  endtask : t_lower
  task automatic t_upper();
    run_cycle(~14'h3000, 2'h2, 1'b0);
  endtask : t_upper
  task automatic t_decode();
    run_cycle(~14'h2E80, 2'h3, 1'b0);
    run_cycle(~14'h1F80, 2'h0, 1'b0);
    run_cycle(~14'h0D00, 2'h0, 1'b0);
  endtask : t_decode
  task automatic t_refuse();
    run_cycle(~14'h2480, 2'h3, 1'b1);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_in);
      chk("no retrigger", 1, 32'(drive_out.x_rd_src_n));
    end
    @(posedge clk_in);
    #1;
    cycle_req_in = 1'b0;
  endtask : t_refuse
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    t_reset();
    t_lower();
    t_upper();
    t_decode();
    t_refuse();
    stop_test();
  end
endmodule : tb_core_drive_steering_logic
